// [i2c_slave_with_timeout_tb.sv]
`timescale 1ns/1ps
module i2c_slave_with_timeout_tb
  import i2cs_pkg::*;
;
  logic          sys_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [3:0]    sub_cnt = 4'h0;
  i2cs_axi_req_t req = '0;
  i2cs_axi_rsp_t rsp;
  logic          s_scl_oe_n, s_sda_oe_n, m_scl_oe_n, m_sda_oe_n, irq;
  wire logic     scl = s_scl_oe_n & m_scl_oe_n;
  wire logic     sda = s_sda_oe_n & m_sda_oe_n;
  int            n_mismatch = 0;
  int            compares = 0;
  int            irq_cnt = 0;
  logic [8:0]    rx;
  always #5 sys_clk = ~sys_clk;
  // Sub clock of 16 system cycles keeps one time-out tick near 512 cycles.
  always @(posedge sys_clk) sub_cnt <= sub_cnt + 4'h1;
  always @(posedge sys_clk) if (irq) irq_cnt <= irq_cnt + 1;
  i2cs_top uut (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .axi_req_in(req), .axi_rsp_out(rsp),
    .scl_in(scl), .sda_in(sda), .sub_clk_in(sub_cnt[3]), .scl_oe_n_out(s_scl_oe_n),
    .sda_oe_n_out(s_sda_oe_n), .irq_out(irq));
  i2cs_master_model mst (.sys_clk_in(sys_clk), .scl_in(scl), .sda_in(sda),
    .scl_oe_n_out(m_scl_oe_n), .sda_oe_n_out(m_sda_oe_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
    chk(rsp.bresp, er);
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] er);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    req.rready <= 1'b0;
    chk(rsp.rdata & {24'h0, m}, {24'h0, e});
    chk(rsp.rresp, er);
    @(posedge sys_clk);
  endtask : rd
  task automatic summarize;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_STATUS, 8'hff, STATUS_RESET, AXI_OKAY);
    rd(ADDR_TIMEOUT, 8'hff, TO_RESET, AXI_OKAY);
    rd(8'h14, 8'hff, 8'h00, AXI_SLVERR);
    wr(8'h14, 8'h55, AXI_SLVERR);
    wr(ADDR_OWNADDR, 8'ha4, AXI_OKAY);
    wr(ADDR_MODE, 8'he2, AXI_OKAY);
    wr(ADDR_TIMEOUT, 8'h80, AXI_OKAY);
    mst.start();
    mst.xfer({8'ha4, 1'b1}, rx);
    chk(rx[0], 1'b0);
    chk(irq_cnt, 1);
    rd(ADDR_STATUS, 8'h64, 8'h60, AXI_OKAY);
    rd(ADDR_DATA, 8'h00, 8'h00, AXI_OKAY);
    mst.xfer({8'h3c, 1'b1}, rx);
    chk(rx[0], 1'b0);
    rd(ADDR_STATUS, 8'h80, 8'h80, AXI_OKAY);
    rd(ADDR_DATA, 8'hff, 8'h3c, AXI_OKAY);
    wr(ADDR_STATUS, 8'h08, AXI_OKAY);
    mst.xfer({8'hc3, 1'b1}, rx);
    chk(rx[0], 1'b1);
    chk(irq_cnt, 3);
    rd(ADDR_DATA, 8'hff, 8'hc3, AXI_OKAY);
    mst.stop();
    rd(ADDR_STATUS, 8'h20, 8'h00, AXI_OKAY);
    rd(ADDR_TIMEOUT, 8'hff, 8'h80, AXI_OKAY);
    mst.start();
    mst.xfer({8'ha5, 1'b1}, rx);
    chk(rx[0], 1'b0);
    rd(ADDR_STATUS, 8'h64, 8'h64, AXI_OKAY);
    wr(ADDR_STATUS, 8'h14, AXI_OKAY);
    wr(ADDR_DATA, 8'h5a, AXI_OKAY);
    mst.xfer(9'h1ff, rx);
    chk(rx[8:1], 8'h5a);
    mst.tick(10);
    chk(s_sda_oe_n, 1'b1);
    rd(ADDR_STATUS, 8'h01, 8'h01, AXI_OKAY);
    mst.stop();
    mst.start();
    mst.xfer({8'ha6, 1'b1}, rx);
    chk(rx[0], 1'b1);
    mst.stop();
    mst.start();
    mst.xfer({8'ha4, 1'b1}, rx);
    rd(ADDR_TIMEOUT, 8'h40, 8'h00, AXI_OKAY);
    mst.tick(2000);
    rd(ADDR_TIMEOUT, 8'hff, 8'h40, AXI_OKAY);
    rd(ADDR_STATUS, 8'hff, STATUS_RESET, AXI_OKAY);
    rd(ADDR_OWNADDR, 8'hfe, 8'ha4, AXI_OKAY);
    rd(ADDR_MODE, 8'hff, 8'he2, AXI_OKAY);
    mst.tick(600);
    rd(ADDR_TIMEOUT, 8'hff, 8'h40, AXI_OKAY);
    wr(ADDR_TIMEOUT, 8'h00, AXI_OKAY);
    rd(ADDR_TIMEOUT, 8'hff, 8'h00, AXI_OKAY);
    mst.stop();
    summarize();
  end
  initial begin
    #300000;
    n_mismatch++;
    summarize();
  end
endmodule : i2c_slave_with_timeout_tb

// [i2cs_master_model.sv]
`timescale 1ns/1ps
module i2cs_master_model (
  input  wire logic sys_clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_n_out,
  output logic      sda_oe_n_out
);
  localparam int HALF = 10;
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : tick
  // The slave may stretch the clock, so each high phase waits for the line itself.
  task automatic rise;
    scl_oe_n_out <= 1'b1;
    do @(posedge sys_clk_in); while (!scl_in);
    tick(HALF);
  endtask : rise
  task automatic start;
    sda_oe_n_out <= 1'b0;
    tick(HALF);
    scl_oe_n_out <= 1'b0;
    tick(HALF);
  endtask : start
  task automatic stop;
    sda_oe_n_out <= 1'b0;
    tick(HALF);
    rise();
    sda_oe_n_out <= 1'b1;
    tick(HALF);
  endtask : stop
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_n_out <= tx[i];
      tick(HALF);
      rise();
      rx[i] = sda_in;
      scl_oe_n_out <= 1'b0;
      tick(HALF);
    end
  endtask : xfer
endmodule : i2cs_master_model

// [i2cs_pkg.sv]
package i2cs_pkg;

  // AXI4-Lite register byte addresses (one aligned 32-bit word each).
  localparam logic [7:0] ADDR_DATA    = 8'h00;
  localparam logic [7:0] ADDR_OWNADDR = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h10;

  // Status/control register field positions.
  localparam int ST_BYTE_DONE   = 7;
  localparam int ST_ADDR_MATCH  = 6;
  localparam int ST_BUS_BUSY    = 5;
  localparam int ST_TX_SEL      = 4;
  localparam int ST_ACK_TO_SEND = 3;
  localparam int ST_MASTER_READ = 2;
  localparam int ST_WAKE_EN     = 1;
  localparam int ST_ACK_RX      = 0;
  localparam logic [7:0] STATUS_RESET  = 8'h81;
  localparam logic [7:0] STATUS_SW_MSK = 8'h1e;

  // Mode/enable register fields.
  localparam int MODE_EN_BIT = 1;
  localparam logic [7:0] MODE_RESET  = 8'he0;
  localparam logic [7:0] MODE_WR_MSK = 8'hef;

  // Time-out control register fields.
  localparam int TO_EN_BIT   = 7;
  localparam int TO_FLAG_BIT = 6;
  localparam logic [7:0] TO_RESET = 8'h00;

  // The sub clock divided by 32 sets the time-out tick.
  localparam int SUB_DIV = 32;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum {
    PH_IDLE,
    PH_ADDR,
    PH_AACK,
    PH_RX,
    PH_RACK,
    PH_TX,
    PH_TACK,
    PH_WAIT
  } i2cs_phase_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } i2cs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } i2cs_axi_rsp_t;

endpackage : i2cs_pkg

// [i2cs_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - Start: data falls while clock high.
// - Start sets bus busy flag.
// - Compare seven address bits, interrupt on match.
// - Eighth bit stored as master-read flag.
// - Acknowledge low on ninth clock after match.
// - Address match sets address-match flag.
// - Hold clock low until data write/read.
// - Bytes are eight bits, MSB first.
// - Receiver sends ack-to-send bit on ninth clock.
// - Unacknowledged transmitter releases data, awaits stop.
// - Shift data register holds received/transmit bytes.
// - One interrupt: match, byte done, time-out.
// - Time-out counts after match, cleared by clock fall.
// - Time-out when count exceeds selected period.
// - Stop condition halts time-out counting.
// - Overflow stops counter, clears enable, sets flag.
// - Time-out resets bus logic and status register.
// - Time-out flag cleared only by software.
// - Period is field plus one time-out ticks (32 sub clocks each).
// - Stop clears bus busy flag.
// - Byte-done low in transfer, high at end.
module i2cs_top
  import i2cs_pkg::*;
#(
  parameter logic [7:0] OWN_ADDR_RESET = 8'h00 // Arbitrary neutral value.
) (
  input  wire logic          sys_clk_in,
  input  wire logic          sys_rst_in,
  input  wire i2cs_axi_req_t axi_req_in,
  output i2cs_axi_rsp_t      axi_rsp_out,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  input  wire logic          sub_clk_in,
  output logic               scl_oe_n_out,
  output logic               sda_oe_n_out,
  output logic               irq_out
);

  typedef struct packed {
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic [2:0]    sub_s;
    logic          scl;
    logic          sda;
    logic          sub;
    logic [4:0]    sub_cnt;
    logic [6:0]    to_cnt;
    logic          to_run;
    i2cs_phase_t   phase;
    logic [3:0]    bitn;
    logic [7:0]    shift;
    logic          hold;
    logic          sda_low;
    logic [7:0]    data;
    logic [7:0]    own;
    logic [7:0]    mode;
    logic [7:0]    status;
    logic [7:0]    tocr;
    logic          irq;
    logic          aw_got;
    logic [7:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    i2cs_axi_rsp_t rsp;
  } i2cs_state_t;

  i2cs_state_t s_q;
  i2cs_state_t s_d;

  // The tick divider counts in five bits, so the divide ratio must fit them.
  if (SUB_DIV < 2 || SUB_DIV > 32) begin : g_div_chk
    $error("sub clock divide ratio out of range");
  end

  function automatic logic [7:0] reg_read(input logic [7:0] a, input i2cs_state_t s, output logic ok);
    ok = 1'b1;
    unique case (a)
      ADDR_DATA:    reg_read = s.data;
      ADDR_OWNADDR: reg_read = s.own;
      ADDR_MODE:    reg_read = s.mode;
      ADDR_STATUS:  reg_read = s.status;
      ADDR_TIMEOUT: reg_read = s.tocr;
      default: begin
        reg_read = 8'h00;
        ok       = 1'b0;
      end
    endcase
  endfunction : reg_read

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sub_tick;
  logic       enabled;
  logic       wr_fire;
  logic       rd_fire;
  logic       rd_ok;
  logic [7:0] rd_val;
  logic       timeout;

  always_comb begin
    s_d      = s_q;
    rd_ok    = 1'b0;
    rd_val   = 8'h00;
    enabled  = s_q.mode[MODE_EN_BIT];
    // A change counts only once the second and third stages agree.
    s_d.scl_s = {s_q.scl_s[1:0], scl_in};
    s_d.sda_s = {s_q.sda_s[1:0], sda_in};
    s_d.sub_s = {s_q.sub_s[1:0], sub_clk_in};
    if (s_q.scl_s[2] == s_q.scl_s[1]) begin
      s_d.scl = s_q.scl_s[2];
    end
    if (s_q.sda_s[2] == s_q.sda_s[1]) begin
      s_d.sda = s_q.sda_s[2];
    end
    if (s_q.sub_s[2] == s_q.sub_s[1]) begin
      s_d.sub = s_q.sub_s[2];
    end
    scl_rise  = s_d.scl && !s_q.scl;
    scl_fall  = !s_d.scl && s_q.scl;
    start_det = s_q.scl && s_d.scl && s_q.sda && !s_d.sda;
    stop_det  = s_q.scl && s_d.scl && !s_q.sda && s_d.sda;
    // Divide the sub clock by 32 into a one-cycle tick.
    // The divider restarts on every clock fall, so a stale divider phase
    // can never cut the first period short.
    sub_tick = 1'b0;
    if (!s_q.to_run || scl_fall) begin
      s_d.sub_cnt = 5'd0;
    end else if (s_d.sub && !s_q.sub) begin
      if (s_q.sub_cnt == 5'(SUB_DIV - 1)) begin
        s_d.sub_cnt = 5'd0;
        sub_tick    = 1'b1;
      end else begin
        s_d.sub_cnt = s_q.sub_cnt + 5'd1;
      end
    end
    s_d.irq = 1'b0;

    // Bus protocol engine.
    if (!enabled) begin
      s_d.phase   = PH_IDLE;
      s_d.hold    = 1'b0;
      s_d.sda_low = 1'b0;
    end else if (start_det) begin
      s_d.status[ST_BUS_BUSY] = 1'b1;
      s_d.status[ST_ADDR_MATCH] = 1'b0;
      s_d.phase   = PH_ADDR;
      s_d.bitn    = 4'd0;
      s_d.sda_low = 1'b0;
      s_d.hold    = 1'b0;
      s_d.to_run  = 1'b0;
    end else if (stop_det) begin
      s_d.status[ST_BUS_BUSY] = 1'b0;
      s_d.phase   = PH_IDLE;
      s_d.sda_low = 1'b0;
      s_d.hold    = 1'b0;
      s_d.to_run  = 1'b0;
    end else begin
      if (scl_rise) begin
        unique case (s_q.phase)
          PH_ADDR, PH_RX: begin
            s_d.shift = {s_q.shift[6:0], s_q.sda};
            s_d.bitn  = s_q.bitn + 4'd1;
            if (s_q.phase == PH_RX) begin
              s_d.status[ST_BYTE_DONE] = 1'b0;
            end
          end
          PH_TX: begin
            s_d.bitn = s_q.bitn + 4'd1;
            s_d.status[ST_BYTE_DONE] = 1'b0;
          end
          PH_TACK: s_d.status[ST_ACK_RX] = s_q.sda;
          default: ;
        endcase
      end
      if (scl_fall) begin
        unique case (s_q.phase)
          PH_ADDR: begin
            if (s_q.bitn == 4'd8) begin
              if (s_q.shift[7:1] == s_q.own[7:1]) begin
                s_d.status[ST_ADDR_MATCH]  = 1'b1;
                s_d.status[ST_MASTER_READ] = s_q.shift[0];
                s_d.sda_low = 1'b1;
                s_d.phase   = PH_AACK;
                s_d.irq     = 1'b1;
                s_d.to_run  = s_q.tocr[TO_EN_BIT];
              end else begin
                // No acknowledge; the master must end with a stop.
                s_d.phase = PH_WAIT;
              end
            end
          end
          PH_AACK, PH_RACK: begin
            s_d.sda_low = 1'b0;
            s_d.hold    = 1'b1;
            s_d.bitn    = 4'd0;
            // Direction is chosen at release, after software has set it.
            s_d.phase   = PH_WAIT;
          end
          PH_RX: begin
            if (s_q.bitn == 4'd8) begin
              s_d.data    = s_q.shift;
              s_d.status[ST_BYTE_DONE] = 1'b1;
              s_d.irq     = 1'b1;
              s_d.sda_low = !s_q.status[ST_ACK_TO_SEND];
              s_d.phase   = PH_RACK;
            end
          end
          PH_TX: begin
            if (s_q.bitn == 4'd8) begin
              s_d.sda_low = 1'b0;
              s_d.phase   = PH_TACK;
            end else begin
              s_d.sda_low = !s_q.shift[7];
              s_d.shift   = {s_q.shift[6:0], 1'b0};
            end
          end
          PH_TACK: begin
            s_d.status[ST_BYTE_DONE] = 1'b1;
            s_d.irq = 1'b1;
            if (s_q.status[ST_ACK_RX]) begin
              s_d.phase = PH_WAIT;
            end else begin
              s_d.hold  = 1'b1;
              s_d.bitn  = 4'd0;
              s_d.phase = PH_WAIT;
            end
          end
          default: ;
        endcase
      end
    end

    // Time-out counter; any clock fall restarts the period.
    timeout = 1'b0;
    if (s_q.to_run) begin
      if (scl_fall) begin
        s_d.to_cnt = 7'd0;
      end else if (sub_tick) begin
        s_d.to_cnt = s_q.to_cnt + 7'd1;
        if (s_q.to_cnt >= {1'b0, s_q.tocr[5:0]}) begin
          timeout = 1'b1;
        end
      end
    end else begin
      s_d.to_cnt = 7'd0;
    end

    // AXI4-Lite slave: address and data may arrive in either order.
    s_d.rsp.awready = 1'b0;
    s_d.rsp.wready  = 1'b0;
    s_d.rsp.arready = 1'b0;
    if (axi_req_in.awvalid && !s_q.aw_got && !s_q.rsp.awready) begin
      s_d.rsp.awready = 1'b1;
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !s_q.w_got && !s_q.rsp.wready) begin
      s_d.rsp.wready = 1'b1;
      s_d.w_got  = 1'b1;
      s_d.w_data = axi_req_in.wdata;
      s_d.w_strb = axi_req_in.wstrb;
    end
    wr_fire = s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid;
    if (s_q.rsp.bvalid && axi_req_in.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_got     = 1'b0;
      s_d.w_got      = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      rd_val = reg_read(s_q.aw_addr, s_q, rd_ok);
      s_d.rsp.bresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
      if (s_q.w_strb[0]) begin
        unique case (s_q.aw_addr)
          ADDR_DATA: begin
            s_d.data  = s_q.w_data[7:0];
            s_d.shift = s_q.w_data[7:0];
            // The first bit goes on the data line in the same cycle that the clock is let go.
            if (s_q.hold) begin
              s_d.hold = 1'b0;
              s_d.bitn = 4'd0;
              if (s_q.status[ST_TX_SEL]) begin
                s_d.phase   = PH_TX;
                s_d.sda_low = !s_q.w_data[7];
                s_d.shift   = {s_q.w_data[6:0], 1'b0};
              end else begin
                s_d.phase = PH_RX;
              end
            end
          end
          ADDR_OWNADDR: s_d.own = s_q.w_data[7:0];
          ADDR_MODE: begin
            s_d.mode = s_q.w_data[7:0] & MODE_WR_MSK;
            if (s_q.w_data[MODE_EN_BIT] && !s_q.mode[MODE_EN_BIT]) begin
              s_d.status = (s_q.status & STATUS_SW_MSK) | (STATUS_RESET & ~STATUS_SW_MSK);
            end
          end
          ADDR_STATUS: s_d.status = (s_d.status & ~STATUS_SW_MSK) | (s_q.w_data[7:0] & STATUS_SW_MSK);
          ADDR_TIMEOUT: begin
            s_d.tocr[5:0]       = s_q.w_data[5:0];
            s_d.tocr[TO_EN_BIT] = s_q.w_data[TO_EN_BIT];
            // Software may clear the flag but never set it.
            s_d.tocr[TO_FLAG_BIT] = s_q.tocr[TO_FLAG_BIT] & s_q.w_data[TO_FLAG_BIT];
          end
          default: ;
        endcase
      end
    end
    rd_fire = axi_req_in.arvalid && !s_q.rsp.rvalid && !s_q.rsp.arready;
    if (s_q.rsp.rvalid && axi_req_in.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_d.rsp.arready = 1'b1;
      s_d.rsp.rvalid  = 1'b1;
      rd_val = reg_read(axi_req_in.araddr, s_q, rd_ok);
      s_d.rsp.rdata = {24'h000000, rd_val};
      s_d.rsp.rresp = rd_ok ? AXI_OKAY : AXI_SLVERR;
      // A dummy read only frees a receiver that is being held.
      if (axi_req_in.araddr == ADDR_DATA && !s_q.status[ST_TX_SEL] && s_q.hold) begin
        s_d.hold  = 1'b0;
        s_d.bitn  = 4'd0;
        s_d.phase = PH_RX;
      end
    end

    // Time-out has the last word so it wins over a same-cycle write.
    if (timeout) begin
      s_d.to_run  = 1'b0;
      s_d.tocr[TO_EN_BIT]   = 1'b0;
      s_d.tocr[TO_FLAG_BIT] = 1'b1;
      s_d.irq     = 1'b1;
      s_d.status  = STATUS_RESET;
      s_d.phase   = PH_IDLE;
      s_d.hold    = 1'b0;
      s_d.sda_low = 1'b0;
      s_d.to_cnt  = 7'd0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s_q        <= '0;
      s_q.scl_s  <= 3'b111;
      s_q.sda_s  <= 3'b111;
      s_q.scl    <= 1'b1;
      s_q.sda    <= 1'b1;
      s_q.phase  <= PH_IDLE;
      s_q.own    <= OWN_ADDR_RESET;
      s_q.mode   <= MODE_RESET;
      s_q.status <= STATUS_RESET;
      s_q.tocr   <= TO_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // The slave only ever pulls lines low, so it cannot form a start.
  assign axi_rsp_out  = s_q.rsp;
  assign scl_oe_n_out = !s_q.hold;
  assign sda_oe_n_out = !s_q.sda_low;
  assign irq_out      = s_q.irq;

endmodule : i2cs_top

// [i2cs_top_asserts.sv]
`timescale 1ns/1ps
module i2cs_top_chk
  import i2cs_pkg::*;
(
  input wire logic          sys_clk_in,
  input wire logic          sys_rst_in,
  input wire i2cs_axi_req_t axi_req_in,
  input wire i2cs_axi_rsp_t axi_rsp_out,
  input wire logic          scl_in,
  input wire logic          sda_in,
  input wire logic          scl_oe_n_out,
  input wire logic          sda_oe_n_out,
  input wire logic          irq_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // A data edge while the clock line is high would look like a start or stop.
  no_start_a: assert property ($fell(sda_oe_n_out) |-> !scl_in)
    else $error("data pulled low while clock high");
  sda_release_a: assert property ($rose(sda_oe_n_out) |-> !scl_in)
    else $error("data released while clock high");
  scl_hold_a: assert property ($fell(scl_oe_n_out) |-> !scl_in)
    else $error("clock hold began while clock high");
  irq_pulse_a: assert property (irq_out |=> !irq_out)
    else $error("interrupt longer than one cycle");
  rdata_upper_a: assert property (axi_rsp_out.rvalid |-> axi_rsp_out.rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rvalid_hold_a: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
                                  |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read answer dropped early");
  bvalid_hold_a: assert property (axi_rsp_out.bvalid && !axi_req_in.bready |=> axi_rsp_out.bvalid)
    else $error("write answer dropped early");
  ar_pair_a: assert property (axi_rsp_out.arready |-> axi_rsp_out.rvalid)
    else $error("read accept without data");
  aw_cause_a: assert property ($rose(axi_rsp_out.awready) |-> $past(axi_req_in.awvalid))
    else $error("write address accepted unasked");
endmodule : i2cs_top_chk
bind i2cs_top i2cs_top_chk chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .scl_in(scl_in), .sda_in(sda_in),
  .scl_oe_n_out(scl_oe_n_out), .sda_oe_n_out(sda_oe_n_out), .irq_out(irq_out));
